// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import tmcg_pkg::*;
  // ========================================
  // Stimulus
  logic clk = 0, rst = 1, lock = 0, twos = 0, p1 = 1, p2 = 0;
  logic [3:0] exc = 0, en = 4'hf, byp;
  logic [31:0] lim = 0;
  logic [4:0] cond = 0;
  logic [23:0] fmax = 24'h302010, fauto = 24'h050403, duty;
  logic wr, rd, ot, ota, al, q1, e1, q2, e2;
  logic [7:0] addr, wd, rdat, v;
  logic [7:0] regs[5] = '{8'h7d, 8'h7e, 8'h7f, 8'h80, 8'h81};
  tmcg_pin_func_t pf;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  always #4 clk = ~clk;
  tmcg_host i_host (.i_clk(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rd), .o_addr(addr),
    .o_wdata(wd));
  tmcg_regs i_dut (.i_clk(clk), .i_rst(rst), .i_wr(wr), .i_rd(rd), .i_addr(addr),
    .i_wdata(wd), .o_rdata(rdat), .i_lock(lock), .i_twos_fmt(twos), .i_ot_exceed(exc),
    .i_ot_limit(lim), .i_ot_chan_en(en), .i_fan_max(fmax), .i_fan_auto(fauto),
    .i_limit_cond(cond), .o_pin_func(pf), .o_overtemp_signal(ot), .o_overtemp_active(ota),
    .o_fan_duty(duty), .o_bypass_divider(byp), .o_alert(al),
    .i_general_io_pin_one(e1 ? q1 : p1), .i_general_io_pin_two(e2 ? q2 : p2),
    .o_general_io_pin_one(q1), .o_general_io_pin_one_oe(e1),
    .o_general_io_pin_two(q2), .o_general_io_pin_two_oe(e2));
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, e);
    i_host.rd(a, v);
    chk(v, e);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ========================================
  // Scenarios
  task automatic t_reset;
    foreach (regs[i]) rc(regs[i], 8'h00);
    chk({pf, e1, q1, e2, q2}, 6'h0f);
  endtask
  task automatic t_cfg;
    for (int f = 0; f < 4; f++) begin
      i_host.wr(8'h7d, 8'hf0 | 8'(f));
      chk({pf, byp}, {2'(f), 4'hf});
    end
    lock = 1;
    i_host.wr(8'h7d, 8'h00);
    rc(8'h7d, 8'hf3);
    lock = 0;
  endtask
  task automatic t_ot;
    {lim, exc} = {32'h50505050, 4'h1};
    i_host.wr(8'h7d, 8'h00);
    chk({ot, duty}, {1'b1, 24'hffffff});
    i_host.wr(8'h7d, 8'h08);
    chk({ot, duty}, {1'b1, fmax});
    i_host.wr(8'h7d, 8'h04);
    chk(ot, 1'b0);
    i_host.wr(8'h7d, 8'h00);
    lim[7:0] = 8'h00;
    #1 chk({ota, duty}, {1'b0, fauto});
    twos = 1;
    #1 chk(ota, 1'b1);
    lim[7:0] = 8'h80;
    #1 chk(ota, 1'b0);
    {exc, twos} = 0;
  endtask
  task automatic t_gio;
    i_host.wr(8'h80, 8'h28);
    chk({e1, q1, e2, q2}, 4'hf);
    i_host.wr(8'h80, 8'h18);
    chk({e1, q1, e2, q2}, 4'ha);
    i_host.wr(8'h80, 8'hc0);
    chk({e1, e2}, 2'b00);
    rc(8'h80, 8'hc8);
    {p1, p2} = 2'b01;
    rc(8'h80, 8'hc4);
  endtask
  task automatic t_stat;
    i_host.wr(8'h83, 8'h08);
    cond = 5'h01;
    repeat (2) @(negedge clk);
    chk(al, 1'b0);
    rc(8'h81, 8'h08);
    rc(8'h81, 8'h08);
    cond = 0;
    rc(8'h81, 8'h08);
    rc(8'h81, 8'h00);
    cond = 5'h1e;
    repeat (2) @(negedge clk);
    chk(al, 1'b1);
    rc(8'h81, 8'hf0);
    cond = 0;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 0;
    t_reset();
    t_cfg();
    t_ot();
    t_gio();
    t_stat();
    end_sim();
  end
  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      n_mismatch++;
      end_sim();
    end
  end
endmodule // testbench

// file: tmcg_gio_pin.sv
`timescale 1ns/1ps
module tmcg_gio_pin (
  // Configuration
  input  wire logic i_dir_in,
  input  wire logic i_pol_high,
  input  wire logic i_data,
  // Pin
  input  wire logic i_pin,
  output logic      o_pin,
  output logic      o_pin_oe,
  // Read value
  output logic      o_rd
);
  // ============================================================
  // Drive and readback
  assign o_pin_oe = ~i_dir_in;
  assign o_pin    = i_pol_high ? i_data : ~i_data;
  assign o_rd     = i_dir_in ? i_pin : i_data;
endmodule // tmcg_gio_pin

// file: tmcg_host.sv
`timescale 1ns/1ps
module tmcg_host (
  // Bus
  input  logic       i_clk,
  input  logic [7:0] i_rdata,
  output logic       o_wr, o_rd,
  output logic [7:0] o_addr, o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
  // Test registers are only read, never written
  task automatic wr(input logic [7:0] a, d);
    @(negedge i_clk);
    {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
    @(negedge i_clk);
    o_wr = 0;
  endtask
  // Read data is combinational, so it is taken just before the edge that
  // clears the status flags; sampling at the edge itself would race the clear
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk);
    {o_addr, o_rd} = {a, 1'b1};
    #3;
    d = i_rdata;
    @(posedge i_clk);
    @(negedge i_clk);
    o_rd = 0;
  endtask
endmodule // tmcg_host

// file: tmcg_params.svh
`ifndef TMCG_PARAMS_SVH
`define TMCG_PARAMS_SVH

// ============================================================
// Register offsets
`define TMCG_OFS_PINCFG   8'h7d
`define TMCG_OFS_TEST1    8'h7e
`define TMCG_OFS_TEST2    8'h7f
`define TMCG_OFS_GIO      8'h80
`define TMCG_OFS_STAT4    8'h81
`define TMCG_OFS_MASK4    8'h83

// ============================================================
// Reset values
`define TMCG_RST_PINCFG   8'h00
`define TMCG_RST_TEST     8'h00
`define TMCG_RST_GIO      8'h00
`define TMCG_RST_STAT4    8'h00
`define TMCG_RST_MASK4    8'h00

// ============================================================
// Field positions, configuration register
`define TMCG_PF_LO        0
`define TMCG_PF_HI        1
`define TMCG_OT_OFF       2
`define TMCG_FAN_RESP     3
`define TMCG_BYP_LO       4
`define TMCG_BYP_HI       7

// ============================================================
// Field positions, general I/O register
`define TMCG_GIO_D2       2
`define TMCG_GIO_D1       3
`define TMCG_GIO_P2       4
`define TMCG_GIO_P1       5
`define TMCG_GIO_R2       6
`define TMCG_GIO_R1       7

// ============================================================
// Field positions, status register
`define TMCG_ST_LO        3
`define TMCG_ST_HI        7
`define TMCG_ST_RSV_MASK  8'hf8

// ============================================================
// Disabled-limit codes and full duty
`define TMCG_LIM_OFS64    8'h00
`define TMCG_LIM_TWOS     8'h80
`define TMCG_DUTY_FULL    8'hff

`endif

// file: tmcg_pkg.sv
package tmcg_pkg;
  typedef enum logic [1:0] {
    TMCG_PIN_TACH,
    TMCG_PIN_OVERTEMP,
    TMCG_PIN_ALERT,
    TMCG_PIN_RSV
  } tmcg_pin_func_t;
endpackage

// file: tmcg_regs.sv
`timescale 1ns/1ps
`include "tmcg_params.svh"
// Functional notes
// - Once lock is set, configuration register writes are ignored.
// - Pin function field: 00 tach, 01 overtemp, 10 alert, 11 reserved.
// - Overtemp output driven when disable bit clear and channels configured.
// - Disable bit set suppresses overtemp output on all channels.
// - Offset-64 format: limit of minus 64 disables that channel.
// - Twos-complement format: limit of minus 128 disables that channel.
// - Fan-response bit clear: overtemp forces all fans to full duty.
// - Fan-response bit set: overtemp drives each fan at its maximum duty.
// - Bypass bits rescale the four voltage channels to 0 to 2.25 V.
// - Input pin reads pin level; output pin driven from written bit.
// - Polarity bit: 0 active low, 1 active high.
// - Direction bit: 1 input, 0 output; register resets to zero.
// - Status bits 3 to 5 set when client reading exceeds limits.
// - Bit 6 current monitor, bit 7 termination voltage; bits 0-2 reserved.
// - Read clears a flag only if its condition has gone.
// - Mask bit blocks alert for the matching status flag.
module tmcg_regs
  import tmcg_pkg::*;
#(
  parameter int NCH  = 4,
  parameter int NFAN = 3
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  // Register access port
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  input  wire logic [7:0]              i_addr,
  input  wire logic [7:0]              i_wdata,
  output logic      [7:0]              o_rdata,
  // Global state
  input  wire logic                    i_lock,
  input  wire logic                    i_twos_fmt,
  // Overtemperature sources
  input  wire logic [NCH-1:0]          i_ot_exceed,
  input  wire logic [NCH*8-1:0]        i_ot_limit,
  input  wire logic [NCH-1:0]          i_ot_chan_en,
  input  wire logic [NFAN*8-1:0]       i_fan_max,
  input  wire logic [NFAN*8-1:0]       i_fan_auto,
  // Limit conditions
  input  wire logic [4:0]              i_limit_cond,
  // Outputs
  output tmcg_pkg::tmcg_pin_func_t     o_pin_func,
  output logic                         o_overtemp_signal,
  output logic                         o_overtemp_active,
  output logic      [NFAN*8-1:0]       o_fan_duty,
  output logic      [3:0]              o_bypass_divider,
  output logic                         o_alert,
  // General pins
  input  wire logic                    i_general_io_pin_one,
  input  wire logic                    i_general_io_pin_two,
  output logic                         o_general_io_pin_one,
  output logic                         o_general_io_pin_one_oe,
  output logic                         o_general_io_pin_two,
  output logic                         o_general_io_pin_two_oe
);
  // ============================================================
  // Registers
  logic [7:0] pin_and_overtemp_config_r;
  logic [7:0] general_io_config_r;
  logic [7:0] limit_status_four_r;
  logic [7:0] limit_mask_four_r;
  logic [NCH-1:0] ot_live;
  logic [7:0] cond_bits;
  logic       rd_one;
  logic       rd_two;

  function automatic logic lim_disabled(input logic [7:0] lim, input logic twos);
    lim_disabled = twos ? (lim == `TMCG_LIM_TWOS) : (lim == `TMCG_LIM_OFS64);
  endfunction

  // ============================================================
  // Configuration register
  // Lock is owned by the first configuration register outside this block
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_and_overtemp_config_r <= `TMCG_RST_PINCFG;
    end else if (i_wr && i_addr == `TMCG_OFS_PINCFG && !i_lock) begin
      pin_and_overtemp_config_r <= i_wdata;
    end
  end

  assign o_pin_func = tmcg_pin_func_t'(
    pin_and_overtemp_config_r[`TMCG_PF_HI:`TMCG_PF_LO]);
  assign o_bypass_divider =
    pin_and_overtemp_config_r[`TMCG_BYP_HI:`TMCG_BYP_LO];

  // ============================================================
  // Overtemperature qualification
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ot_live[i] = i_ot_exceed[i] && i_ot_chan_en[i] &&
                   !lim_disabled(i_ot_limit[i*8 +: 8], i_twos_fmt);
    end
  end

  // Fan override stays live even when the pin output is disabled
  assign o_overtemp_active = |ot_live;
  assign o_overtemp_signal = o_overtemp_active &&
    !pin_and_overtemp_config_r[`TMCG_OT_OFF];

  always_comb begin
    for (int f = 0; f < NFAN; f++) begin
      if (!o_overtemp_active) begin
        o_fan_duty[f*8 +: 8] = i_fan_auto[f*8 +: 8];
      end else if (pin_and_overtemp_config_r[`TMCG_FAN_RESP]) begin
        o_fan_duty[f*8 +: 8] = i_fan_max[f*8 +: 8];
      end else begin
        o_fan_duty[f*8 +: 8] = `TMCG_DUTY_FULL;
      end
    end
  end

  // ============================================================
  // General I/O register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      general_io_config_r <= `TMCG_RST_GIO;
    end else if (i_wr && i_addr == `TMCG_OFS_GIO) begin
      general_io_config_r <= i_wdata & 8'hfc;
    end
  end

  tmcg_gio_pin u_pin_one (
    .i_dir_in   (general_io_config_r[`TMCG_GIO_R1]),
    .i_pol_high (general_io_config_r[`TMCG_GIO_P1]),
    .i_data     (general_io_config_r[`TMCG_GIO_D1]),
    .i_pin      (i_general_io_pin_one),
    .o_pin      (o_general_io_pin_one),
    .o_pin_oe   (o_general_io_pin_one_oe),
    .o_rd       (rd_one)
  );

  tmcg_gio_pin u_pin_two (
    .i_dir_in   (general_io_config_r[`TMCG_GIO_R2]),
    .i_pol_high (general_io_config_r[`TMCG_GIO_P2]),
    .i_data     (general_io_config_r[`TMCG_GIO_D2]),
    .i_pin      (i_general_io_pin_two),
    .o_pin      (o_general_io_pin_two),
    .o_pin_oe   (o_general_io_pin_two_oe),
    .o_rd       (rd_two)
  );

  // ============================================================
  // Limit status and mask
  assign cond_bits = {i_limit_cond, 3'b000};

  // Set wins over a clearing read, so no event is lost
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      limit_status_four_r <= `TMCG_RST_STAT4;
    end else if (i_rd && i_addr == `TMCG_OFS_STAT4) begin
      limit_status_four_r <= cond_bits;
    end else begin
      limit_status_four_r <= limit_status_four_r | cond_bits;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      limit_mask_four_r <= `TMCG_RST_MASK4;
    end else if (i_wr && i_addr == `TMCG_OFS_MASK4 && !i_lock) begin
      limit_mask_four_r <= i_wdata & `TMCG_ST_RSV_MASK;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_alert <= 1'b0;
    end else begin
      o_alert <= |(limit_status_four_r & ~limit_mask_four_r);
    end
  end

  // ============================================================
  // Read data
  always_comb begin
    case (i_addr)
      `TMCG_OFS_PINCFG: o_rdata = pin_and_overtemp_config_r;
      `TMCG_OFS_TEST1:  o_rdata = `TMCG_RST_TEST;
      `TMCG_OFS_TEST2:  o_rdata = `TMCG_RST_TEST;
      `TMCG_OFS_GIO:    o_rdata = {general_io_config_r[7:4], rd_one, rd_two, 2'b00};
      `TMCG_OFS_STAT4:  o_rdata = limit_status_four_r;
      `TMCG_OFS_MASK4:  o_rdata = limit_mask_four_r;
      default:          o_rdata = 8'h00;
    endcase
  end
endmodule // tmcg_regs

// file: tmcg_regs_sva.sv
`timescale 1ns/1ps
module tmcg_regs_sva
  import tmcg_pkg::*;
#(parameter int NCH = 4, parameter int NFAN = 3) (
  // Bus
  input logic                     i_clk, i_rst, i_wr, i_rd, i_lock,
  input logic [7:0]               i_addr, i_wdata, o_rdata,
  input logic [4:0]               i_limit_cond,
  // Outputs
  input tmcg_pkg::tmcg_pin_func_t o_pin_func,
  input logic                     o_overtemp_signal, o_overtemp_active,
  input logic [NFAN*8-1:0]        o_fan_duty, i_fan_max,
  input logic [3:0]               o_bypass_divider,
  input logic                     i_general_io_pin_two, o_general_io_pin_one,
  input logic                     o_general_io_pin_one_oe, o_general_io_pin_two_oe
);
  logic [7:0] wd_q;
  always_ff @(posedge i_clk) wd_q <= i_wdata;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ========================================
  // Steps
  sequence cfg_wr; i_wr && i_addr == 8'h7d && !i_lock; endsequence
  sequence gio_wr; i_wr && i_addr == 8'h80; endsequence
  chk_lock_hold: assert property (
    i_wr && i_addr == 8'h7d && i_lock |=> $stable(o_pin_func) && $stable(o_bypass_divider))
    else $error("locked write took effect");
  chk_cfg_fields: assert property (
    cfg_wr |=> o_pin_func == wd_q[1:0] && o_bypass_divider == wd_q[7:4])
    else $error("config fields wrong");
  chk_ot_off: assert property (cfg_wr ##0 i_wdata[2] |=> !o_overtemp_signal)
    else $error("overtemp not suppressed");
  chk_fan_full: assert property (
    cfg_wr ##0 i_wdata[3:2] == 2'b00 ##1 o_overtemp_active |-> o_fan_duty == {NFAN{8'hff}})
    else $error("fan not full");
  chk_fan_max: assert property (
    cfg_wr ##0 i_wdata[3:2] == 2'b10 ##1 o_overtemp_active |-> o_fan_duty == i_fan_max)
    else $error("fan not at max");
  chk_gio_dir: assert property (
    gio_wr |=> o_general_io_pin_one_oe == !wd_q[7] && o_general_io_pin_two_oe == !wd_q[6])
    else $error("pin direction wrong");
  chk_gio_drive: assert property (
    gio_wr |=> o_general_io_pin_one == (wd_q[3] ~^ wd_q[5]))
    else $error("pin level wrong");
  chk_stat_set: assert property (
    i_limit_cond != 5'h00 ##1 i_addr == 8'h81
    |-> (o_rdata[7:3] & $past(i_limit_cond)) == $past(i_limit_cond) && o_rdata[2:0] == 3'h0)
    else $error("status flag missing");
  chk_stat_clear: assert property (
    i_rd && i_addr == 8'h81 ##1 i_addr == 8'h81 |-> o_rdata[7:3] == $past(i_limit_cond))
    else $error("status clear wrong");
endmodule // tmcg_regs_sva
bind tmcg_regs tmcg_regs_sva #(.NCH(NCH), .NFAN(NFAN)) i_sva (.i_clk, .i_rst, .i_wr, .i_rd,
  .i_lock, .i_addr, .i_wdata, .o_rdata, .i_limit_cond, .o_pin_func, .o_overtemp_signal,
  .o_overtemp_active, .o_fan_duty, .i_fan_max, .o_bypass_divider, .i_general_io_pin_two,
  .o_general_io_pin_one, .o_general_io_pin_one_oe, .o_general_io_pin_two_oe);
